// ---- common/tpd_pkg.sv ----
// package: constants and types of the three-phase pwm input decoder
package tpd_pkg;
  localparam int TPD_PHASES = 3;
  localparam int TPD_PIN_W = 2 * TPD_PHASES;
  // drive scheme codes
  localparam logic [1:0] TPD_MODE_SIX = 2'h0;
  localparam logic [1:0] TPD_MODE_THREE = 2'h1;
  localparam logic [1:0] TPD_MODE_ONE = 2'h2;
  localparam logic [1:0] TPD_MODE_INDEP = 2'h3;
  // register port
  localparam int TPD_ADDR_W = 4;
  localparam int TPD_DATA_W = 32;
  localparam logic [3:0] TPD_REG_CTRL = 4'h0;
  localparam logic [3:0] TPD_REG_STAT = 4'h4;
  // control fields
  localparam int TPD_CTRL_MODE_LSB = 0;
  localparam int TPD_CTRL_FW_BIT = 2;
  // status fields
  localparam int TPD_STAT_UP_LSB = 0;
  localparam int TPD_STAT_LO_LSB = 3;
  localparam int TPD_STAT_STEP_LSB = 6;
  localparam int TPD_STAT_DIR_BIT = 9;
  localparam int TPD_STAT_BRK_BIT = 10;
  localparam int TPD_STAT_ERR_BIT = 11;
  localparam int TPD_STAT_MODE_LSB = 12;
  // values after reset
  localparam logic [1:0] TPD_MODE_RST = 2'h0;
  localparam logic TPD_FW_RST = 1'b0;
  localparam logic [TPD_PIN_W-1:0] TPD_SYNC_RST = 6'h00;
  localparam logic [TPD_PHASES-1:0] TPD_GATE_RST = 3'h0;
  localparam logic [TPD_DATA_W-1:0] TPD_RDATA_RST = 32'h0000_0000;
  // commutation steps of single-pwm mode
  typedef enum logic [2:0] {
    TPD_STEP_STOP,
    TPD_STEP_ALIGN,
    TPD_STEP_B_C,
    TPD_STEP_A_C,
    TPD_STEP_A_B,
    TPD_STEP_C_B,
    TPD_STEP_C_A,
    TPD_STEP_B_A
  } tpd_step_t;
endpackage

// ---- common/tpd_cmd_if.sv ----
// interface: synchronised command inputs between synchroniser and decoder
`timescale 1ns/1ns
interface tpd_cmd_if;
  logic [2:0] high;
  logic [2:0] low;
  modport src (output high, output low);
  modport dst (input high, input low);
endinterface

// ---- rtl/tpd_sync.sv ----
// module: two-stage synchroniser for the six command pins
`timescale 1ns/1ns
module tpd_sync
  import tpd_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [TPD_PHASES-1:0] high_cmd_in_i,
  input wire logic [TPD_PHASES-1:0] low_cmd_in_i,
  tpd_cmd_if.src cmd
);
  logic [TPD_PIN_W-1:0] raw;
  logic [TPD_PIN_W-1:0] meta_q;
  logic [TPD_PIN_W-1:0] stab_q;

  assign raw = {low_cmd_in_i, high_cmd_in_i};

  // first stage feeds only the second stage
  for (genvar g = 0; g < TPD_PIN_W; g++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        meta_q[g] <= TPD_SYNC_RST[g];
        stab_q[g] <= TPD_SYNC_RST[g];
      end else begin
        meta_q[g] <= raw[g];
        stab_q[g] <= meta_q[g];
      end
    end
  end

  assign cmd.high = stab_q[TPD_PHASES-1:0];
  assign cmd.low = stab_q[TPD_PIN_W-1:TPD_PHASES];
endmodule

// ---- rtl/tpd_decoder.sv ----
// module: pwm input decoder driving three half-bridge gate commands
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ns
module tpd_decoder
  import tpd_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [TPD_PHASES-1:0] high_cmd_in_i,
  input wire logic [TPD_PHASES-1:0] low_cmd_in_i,
  input wire logic [TPD_ADDR_W-1:0] reg_addr_i,
  input wire logic [TPD_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [TPD_DATA_W-1:0] reg_rdata_o,
  output logic [TPD_PHASES-1:0] upper_gate_out_o,
  output logic [TPD_PHASES-1:0] lower_gate_out_o
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic tpd_step_t step_of(input logic [2:0] code,
                                        input logic dir);
    logic [2:0] c;
    c = dir ? ~code : code;
    step_of = TPD_STEP_STOP;
    if (code == 3'h7) begin
      step_of = TPD_STEP_ALIGN;
    end else if (code != 3'h0) begin
      case (c)
        3'h6: step_of = TPD_STEP_B_C;
        3'h4: step_of = TPD_STEP_A_C;
        3'h5: step_of = TPD_STEP_A_B;
        3'h1: step_of = TPD_STEP_C_B;
        3'h3: step_of = TPD_STEP_C_A;
        3'h2: step_of = TPD_STEP_B_A;
        default: step_of = TPD_STEP_STOP;
      endcase
    end
  endfunction

  // returns {upper, lower}, phase A in bit 0
  function automatic logic [5:0] one_pwm(input tpd_step_t st,
                                         input logic pwm,
                                         input logic fw);
    logic [2:0] up;
    logic [2:0] lo;
    int src;
    int snk;
    logic act;
    up = '0;
    lo = '0;
    src = 0;
    snk = 0;
    act = 1'b1;
    case (st)
      TPD_STEP_ALIGN: begin
        src = 0;
        snk = 1;
        lo[2] = 1'b1;
      end
      TPD_STEP_B_C: begin
        src = 1;
        snk = 2;
      end
      TPD_STEP_A_C: begin
        src = 0;
        snk = 2;
      end
      TPD_STEP_A_B: begin
        src = 0;
        snk = 1;
      end
      TPD_STEP_C_B: begin
        src = 2;
        snk = 1;
      end
      TPD_STEP_C_A: begin
        src = 2;
        snk = 0;
      end
      TPD_STEP_B_A: begin
        src = 1;
        snk = 0;
      end
      default: act = 1'b0;
    endcase
    if (act) begin
      up[src] = pwm;
      lo[src] = fw ? 1'b0 : ~pwm;
      lo[snk] = 1'b1;
    end
    one_pwm = {up, lo};
  endfunction

  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  tpd_cmd_if cmd ();

  tpd_sync u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .high_cmd_in_i(high_cmd_in_i),
    .low_cmd_in_i(low_cmd_in_i),
    .cmd(cmd)
  );

  logic [TPD_PHASES-1:0] hi_s;
  logic [TPD_PHASES-1:0] lo_s;
  assign hi_s = cmd.high;
  assign lo_s = cmd.low;

  // single-pwm roles of the pins
  logic pwm_source_in;
  logic [2:0] state_code;
  logic direction_in;
  logic brake_n_in;
  assign pwm_source_in = hi_s[0];
  assign state_code = {lo_s[0], hi_s[1], lo_s[1]};
  assign direction_in = hi_s[2];
  assign brake_n_in = lo_s[2];

  // ----------------------------------------
  // control and status registers
  // ----------------------------------------
  logic [1:0] mode_q;
  logic freewheel_sel_q;
  logic mode_err_q;
  logic [TPD_DATA_W-1:0] reg_rdata_q;
  logic wr_ctrl;
  logic wr_stat;
  logic [1:0] mode_wr;
  tpd_step_t step_w;
  tpd_step_t step_q;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == TPD_REG_CTRL);
  assign wr_stat = reg_wr_i && (reg_addr_i == TPD_REG_STAT);
  assign mode_wr = reg_wdata_i[TPD_CTRL_MODE_LSB +: 2];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_q <= TPD_MODE_RST;
      freewheel_sel_q <= TPD_FW_RST;
    end else if (wr_ctrl) begin
      mode_q <= mode_wr;
      freewheel_sel_q <= reg_wdata_i[TPD_CTRL_FW_BIT];
    end
  end

  // flag mode change with live inputs
  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_err_q <= 1'b0;
    end else if (wr_ctrl && (mode_wr != mode_q) && ((hi_s | lo_s) != '0)) begin
      mode_err_q <= 1'b1;
    end else if (wr_stat && reg_wdata_i[TPD_STAT_ERR_BIT]) begin
      mode_err_q <= 1'b0;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_q <= TPD_RDATA_RST;
    end else begin
      reg_rdata_q <= TPD_RDATA_RST;
      if (reg_rd_i) begin
        case (reg_addr_i)
          TPD_REG_CTRL: begin
            reg_rdata_q[TPD_CTRL_MODE_LSB +: 2] <= mode_q;
            reg_rdata_q[TPD_CTRL_FW_BIT] <= freewheel_sel_q;
          end
          TPD_REG_STAT: begin
            reg_rdata_q[TPD_STAT_UP_LSB +: 3] <= upper_gate_out_o;
            reg_rdata_q[TPD_STAT_LO_LSB +: 3] <= lower_gate_out_o;
            reg_rdata_q[TPD_STAT_STEP_LSB +: 3] <= step_q;
            reg_rdata_q[TPD_STAT_DIR_BIT] <= direction_in;
            reg_rdata_q[TPD_STAT_BRK_BIT] <= ~brake_n_in;
            reg_rdata_q[TPD_STAT_ERR_BIT] <= mode_err_q;
            reg_rdata_q[TPD_STAT_MODE_LSB +: 2] <= mode_q;
          end
          default: reg_rdata_q <= TPD_RDATA_RST;
        endcase
      end
    end
  end
  assign reg_rdata_o = reg_rdata_q;

  // ----------------------------------------
  // per-phase decoders
  // ----------------------------------------
  logic [TPD_PHASES-1:0] six_up;
  logic [TPD_PHASES-1:0] six_lo;
  logic [TPD_PHASES-1:0] thr_up;
  logic [TPD_PHASES-1:0] thr_lo;

  for (genvar p = 0; p < TPD_PHASES; p++) begin : g_phase
    assign six_up[p] = hi_s[p] & ~lo_s[p];
    assign six_lo[p] = lo_s[p] & ~hi_s[p];
    assign thr_up[p] = lo_s[p] & hi_s[p];
    assign thr_lo[p] = lo_s[p] & ~hi_s[p];
  end

  // ----------------------------------------
  // mode select and gate registers
  // ----------------------------------------
  logic [TPD_PHASES-1:0] upper_d;
  logic [TPD_PHASES-1:0] lower_d;
  logic [TPD_PHASES-1:0] upper_q;
  logic [TPD_PHASES-1:0] lower_q;

  assign step_w = step_of(state_code, direction_in);

  always_comb begin
    upper_d = TPD_GATE_RST;
    lower_d = TPD_GATE_RST;
    case (mode_q)
      TPD_MODE_SIX: begin
        upper_d = six_up;
        lower_d = six_lo;
      end
      TPD_MODE_THREE: begin
        upper_d = thr_up;
        lower_d = thr_lo;
      end
      TPD_MODE_ONE: begin
        if (!brake_n_in) begin
          upper_d = '0;
          lower_d = '1;
        end else begin
          {upper_d, lower_d} = one_pwm(step_w, pwm_source_in, freewheel_sel_q);
        end
      end
      TPD_MODE_INDEP: begin
        upper_d = hi_s;
        lower_d = lo_s;
      end
      default: begin
        upper_d = TPD_GATE_RST;
        lower_d = TPD_GATE_RST;
      end
    endcase
  end

  // gates off while reset is held
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      upper_q <= TPD_GATE_RST;
      lower_q <= TPD_GATE_RST;
      step_q <= TPD_STEP_STOP;
    end else begin
      upper_q <= upper_d;
      lower_q <= lower_d;
      step_q <= step_w;
    end
  end
  assign upper_gate_out_o = upper_q;
  assign lower_gate_out_o = lower_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic one_ok;
  assign one_ok = (mode_q == TPD_MODE_ONE) && brake_n_in;

  six_float_a: assert property (
    (mode_q == TPD_MODE_SIX) && (hi_s[0] == lo_s[0])
    |=> !upper_gate_out_o[0] && !lower_gate_out_o[0])
    else $error("six-input float not applied");

  six_drive_a: assert property (
    (mode_q == TPD_MODE_SIX) && hi_s[1] && !lo_s[1]
    |=> upper_gate_out_o[1] && !lower_gate_out_o[1])
    else $error("six-input high drive wrong");

  three_float_a: assert property (
    (mode_q == TPD_MODE_THREE) && !lo_s[1]
    |=> !upper_gate_out_o[1] && !lower_gate_out_o[1])
    else $error("three-input float not applied");

  three_level_a: assert property (
    (mode_q == TPD_MODE_THREE) && lo_s[2]
    |=> (upper_gate_out_o[2] == $past(hi_s[2]))
        && (lower_gate_out_o[2] != upper_gate_out_o[2]))
    else $error("three-input level wrong");

  one_stop_a: assert property (
    one_ok && (state_code == 3'h0)
    |=> (upper_gate_out_o == '0) && (lower_gate_out_o == '0))
    else $error("stop code drives a gate");

  one_align_a: assert property (
    one_ok && (state_code == 3'h7) && !freewheel_sel_q
    |=> (upper_gate_out_o == {2'b00, $past(pwm_source_in)})
        && (lower_gate_out_o == {2'b11, !$past(pwm_source_in)}))
    else $error("align outputs wrong");

  one_step_a: assert property (
    one_ok && !direction_in && (state_code == 3'h6) && !freewheel_sel_q
    |=> (upper_gate_out_o == {1'b0, $past(pwm_source_in), 1'b0})
        && (lower_gate_out_o == {1'b1, !$past(pwm_source_in), 1'b0}))
    else $error("step B to C wrong");

  one_dir_a: assert property (
    one_ok && direction_in && (state_code == 3'h6)
    |=> upper_gate_out_o[2] == $past(pwm_source_in) && lower_gate_out_o[1]
        && !upper_gate_out_o[0] && !lower_gate_out_o[0])
    else $error("reverse C to B wrong");

  freewheel_a: assert property (
    one_ok && !direction_in && freewheel_sel_q && (state_code == 3'h4)
    |=> !lower_gate_out_o[0] && lower_gate_out_o[2])
    else $error("source low gate not off");

  brake_a: assert property (
    (mode_q == TPD_MODE_ONE) && !brake_n_in
    |=> (upper_gate_out_o == '0) && (lower_gate_out_o == '1))
    else $error("brake not applied");

  indep_sync_a: assert property (
    (mode_q == TPD_MODE_INDEP) [*4]
    |-> (upper_gate_out_o == $past(high_cmd_in_i, 3))
        && (lower_gate_out_o == $past(low_cmd_in_i, 3)))
    else $error("independent path latency wrong");

  mode_err_a: assert property (
    wr_ctrl && (mode_wr != mode_q) && ((hi_s | lo_s) != '0)
    |=> mode_err_q ##1 (mode_err_q || $past(wr_stat && reg_wdata_i[TPD_STAT_ERR_BIT])))
    else $error("mode change flag lost");

  brake_c: cover property ((mode_q == TPD_MODE_ONE) && !brake_n_in);
  step_c: cover property (one_ok ##1 one_ok && step_w != step_q);
  float_c: cover property ((mode_q == TPD_MODE_THREE) && !lo_s[0]);
  err_c: cover property (mode_err_q && wr_stat);
endmodule

// ---- bench/tpd_ctrl_model.sv ----
// model of the external controller that drives the six command pins
`timescale 1ns/1ns
module tpd_ctrl_model (
  input wire logic clk_i,
  input wire logic idle_i,
  input wire logic pwm_run_i,
  input wire logic [2:0] hi_i,
  input wire logic [2:0] lo_i,
  output logic [2:0] high_cmd_o,
  output logic [2:0] low_cmd_o
);
  logic [2:0] cnt_q = 3'h0;
  logic pwm_q = 1'b0;

  initial begin
    high_cmd_o = 3'h0;
    low_cmd_o = 3'h0;
  end

  // ----------------------------------------
  // pwm source, period of six clocks
  // ----------------------------------------
  always @(posedge clk_i) begin
    cnt_q <= (cnt_q == 3'h5) ? 3'h0 : cnt_q + 3'h1;
    pwm_q <= (cnt_q < 3'h3);
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (idle_i) begin
      high_cmd_o <= 3'h0;
      low_cmd_o <= 3'h0;
    end else begin
      high_cmd_o <= pwm_run_i ? {hi_i[2:1], pwm_q} : hi_i;
      low_cmd_o <= lo_i;
    end
  end
endmodule

// ---- bench/test_three_phase_pwm_input_decoder.sv ----
// self-checking bench of the pwm input decoder
`timescale 1ns/1ns
module test_three_phase_pwm_input_decoder
  import tpd_pkg::*;
;
  typedef struct packed {
    logic [1:0] m;
    logic f;
    logic [2:0] hi;
    logic [2:0] lo;
    logic [2:0] up;
    logic [2:0] dn;
  } tpd_row_t;

  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic idle = 1'b1;
  logic pwm_run = 1'b0;
  logic [2:0] hi = 3'h0;
  logic [2:0] lo = 3'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [2:0] high_cmd;
  logic [2:0] low_cmd;
  logic [2:0] up_g;
  logic [2:0] dn_g;
  logic [2:0] pa_q = 3'h0;
  logic [1:0] cur_m = 2'h0;
  logic cur_f = 1'b0;
  logic [31:0] v;
  int failures = 0;
  int checked = 0;

  // hi = {dir, state b, pwm}, lo = {brake_n, state c, state a}
  // unused controls held idle
  tpd_row_t rows [24] = '{
    '{2'h0, 1'h0, 3'h3, 3'h5, 3'h2, 3'h4}, '{2'h0, 1'h0, 3'h4, 3'h2, 3'h4, 3'h2},
    '{2'h0, 1'h0, 3'h0, 3'h0, 3'h0, 3'h0}, '{2'h1, 1'h0, 3'h5, 3'h6, 3'h4, 3'h2},
    '{2'h1, 1'h0, 3'h2, 3'h7, 3'h2, 3'h5}, '{2'h2, 1'h0, 3'h1, 3'h4, 3'h0, 3'h0},
    '{2'h2, 1'h0, 3'h3, 3'h7, 3'h1, 3'h6}, '{2'h2, 1'h0, 3'h3, 3'h5, 3'h2, 3'h4},
    '{2'h2, 1'h0, 3'h1, 3'h5, 3'h1, 3'h4}, '{2'h2, 1'h0, 3'h1, 3'h7, 3'h1, 3'h2},
    '{2'h2, 1'h0, 3'h1, 3'h6, 3'h4, 3'h2}, '{2'h2, 1'h0, 3'h3, 3'h6, 3'h4, 3'h1},
    '{2'h2, 1'h0, 3'h3, 3'h4, 3'h2, 3'h1}, '{2'h2, 1'h0, 3'h2, 3'h5, 3'h0, 3'h6},
    '{2'h2, 1'h0, 3'h0, 3'h5, 3'h0, 3'h5}, '{2'h2, 1'h0, 3'h5, 3'h6, 3'h2, 3'h4},
    '{2'h2, 1'h0, 3'h7, 3'h5, 3'h4, 3'h2}, '{2'h2, 1'h0, 3'h4, 3'h4, 3'h0, 3'h0},
    '{2'h2, 1'h0, 3'h7, 3'h7, 3'h1, 3'h6}, '{2'h2, 1'h0, 3'h1, 3'h1, 3'h0, 3'h7},
    '{2'h2, 1'h1, 3'h0, 3'h5, 3'h0, 3'h4}, '{2'h2, 1'h1, 3'h2, 3'h7, 3'h0, 3'h6},
    '{2'h3, 1'h0, 3'h5, 3'h7, 3'h5, 3'h7}, '{2'h3, 1'h0, 3'h2, 3'h1, 3'h2, 3'h1}
  };

  always #2 clk_i = ~clk_i;

  always @(posedge clk_i) pa_q <= {pa_q[1:0], high_cmd[0]};

  tpd_ctrl_model ctrl_u (
    .clk_i(clk_i), .idle_i(idle), .pwm_run_i(pwm_run), .hi_i(hi), .lo_i(lo),
    .high_cmd_o(high_cmd), .low_cmd_o(low_cmd)
  );

  tpd_decoder dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .high_cmd_in_i(high_cmd), .low_cmd_in_i(low_cmd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .upper_gate_out_o(up_g), .lower_gate_out_o(dn_g)
  );

  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic chk3(input string nm, input logic [2:0] e, input logic [2:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // set_mode changes mode only with every pin idle low
  task automatic set_mode(input logic [1:0] m, input logic f);
    logic [31:0] c;
    @(posedge clk_i);
    idle <= 1'b1;
    hi <= 3'h0;
    lo <= 3'h0;
    repeat (4) @(posedge clk_i);
    reg_wr(TPD_REG_CTRL, {29'h0, f, m});
    reg_rd(TPD_REG_CTRL, c);
    chk32("ctrl", {29'h0, f, m}, c);
    @(posedge clk_i);
    idle <= 1'b0;
    cur_m = m;
    cur_f = f;
  endtask

  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // hang guard, tests need about 300 cycles
  initial begin
    repeat (6000) @(posedge clk_i);
    failures++;
    test_done();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic fw;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    idle <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      if (rows[i].m !== cur_m || rows[i].f !== cur_f)
        set_mode(rows[i].m, rows[i].f);
      @(posedge clk_i);
      hi <= rows[i].hi;
      lo <= rows[i].lo;
      repeat (5) @(posedge clk_i);
      #1;
      chk3("upper", rows[i].up, up_g);
      chk3("lower", rows[i].dn, dn_g);
    end
    $display("test table done");
    // three clocks from pin to gate in six-input mode
    set_mode(TPD_MODE_SIX, 1'b0);
    @(posedge clk_i);
    hi <= 3'h1;
    lo <= 3'h0;
    repeat (3) @(posedge clk_i);
    #1;
    chk3("upper early", 3'h0, up_g);
    @(posedge clk_i);
    #1;
    chk3("upper late", 3'h1, up_g);
    // mode write with a pin still high
    reg_wr(TPD_REG_CTRL, 32'h0000_0001);
    cur_m = TPD_MODE_THREE;
    reg_rd(TPD_REG_STAT, v);
    chk32("mode err set", 32'h0000_1800, v & 32'h0000_3800);
    reg_wr(TPD_REG_STAT, 32'h0000_0800);
    reg_rd(TPD_REG_STAT, v);
    chk32("mode err clear", 32'h0000_0000, v & 32'h0000_0800);
    reg_rd(4'h8, v);
    chk32("unmapped", 32'h0000_0000, v);
    $display("test latency and registers done");
    // live pwm on step b to c
    for (int f = 0; f < 2; f++) begin
      fw = f[0];
      set_mode(TPD_MODE_ONE, fw);
      @(posedge clk_i);
      hi <= 3'h3;
      lo <= 3'h5;
      pwm_run <= 1'b1;
      repeat (6) @(posedge clk_i);
      repeat (12) begin
        @(negedge clk_i);
        chk3("upper pwm", {1'b0, pa_q[2], 1'b0}, up_g);
        chk3("lower pwm", {1'b1, ~pa_q[2] & ~fw, 1'b0}, dn_g);
      end
      @(posedge clk_i);
      pwm_run <= 1'b0;
    end
    $display("test live pwm done");
    // mid-run reset: gates off, mode back to six-input
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk3("upper in reset", 3'h0, up_g);
    chk3("lower in reset", 3'h0, dn_g);
    reg_rd(TPD_REG_CTRL, v);
    chk32("ctrl after reset", 32'h0000_0000, v);
    repeat (4) @(posedge clk_i);
    #1;
    chk3("upper after reset", 3'h2, up_g);
    chk3("lower after reset", 3'h4, dn_g);
    cur_m = TPD_MODE_SIX;
    cur_f = 1'b0;
    $display("test reset done");
    test_done();
  end
endmodule
